// [rtl/cil_core_interrupt.sv]
// core interrupt logic: flags, enables, vectoring and sleep wake-up
`timescale 1ns/10ps
module cil_core_interrupt
  import cil_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire cil_events_s events,
  input wire logic ext_pin,
  input wire logic ext_edge_select,
  input wire logic instr_cycle,
  input wire logic sleep_op,
  input wire logic return_from_service_op,
  output cil_redirect_s redirect,
  output logic irq_request,
  output logic core_asleep
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] pflag_reg, pflag_next;
  logic [7:0] pen_reg, pen_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ext_pin_reg;
  cil_state_e state_reg, state_next;
  logic [1:0] lat_reg, lat_next;
  logic pend_reg, pend_next;
  logic [2:0] redir_reg, redir_next;
  logic irq_reg, asleep_reg;

  // register index match, shared by write and read decode
  function automatic logic addr_hit(logic [1:0] a, logic [1:0] idx);
    return a == idx;
  endfunction

  wire wr_ctrl = reg_wr && addr_hit(reg_addr, CIL_ADDR_CTRL);
  wire wr_pflag = reg_wr && addr_hit(reg_addr, CIL_ADDR_PFLAG);
  wire wr_pen = reg_wr && addr_hit(reg_addr, CIL_ADDR_PEN);
  wire wr_stat = reg_wr && addr_hit(reg_addr, CIL_ADDR_STAT);

  wire ext_edge = ext_edge_select ? (ext_pin && !ext_pin_reg)
                                  : (!ext_pin && ext_pin_reg);

  wire core_hit = (ctrl_reg[CIL_BIT_T0E] && ctrl_reg[CIL_BIT_T0F]) ||
                  (ctrl_reg[CIL_BIT_EXE] && ctrl_reg[CIL_BIT_EXF]) ||
                  (ctrl_reg[CIL_BIT_PCE] && ctrl_reg[CIL_BIT_PCF]);
  wire periph_hit = ctrl_reg[CIL_BIT_PGE] && |(pen_reg & pflag_reg);
  wire any_hit = core_hit || periph_hit;
  wire wake_src = any_hit;
  wire take = ctrl_reg[CIL_BIT_GIE] && any_hit && (state_reg == CIL_RUN)
              && !pend_reg;

  // flags set by events; set beats software clear
  logic [7:0] ctrl_w;
  assign ctrl_w = wr_ctrl ? reg_wdata : ctrl_reg;
  always_comb begin
    ctrl_next = ctrl_w;
    if (events.timer0_ovf) begin
      ctrl_next[CIL_BIT_T0F] = 1'b1;
    end
    if (events.ext_pin || ext_edge) begin
      ctrl_next[CIL_BIT_EXF] = 1'b1;
    end
    if (events.pin_change) begin
      ctrl_next[CIL_BIT_PCF] = 1'b1;
    end
    if (take) begin
      ctrl_next[CIL_BIT_GIE] = 1'b0;
    end
    if (return_from_service_op) begin
      ctrl_next[CIL_BIT_GIE] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CIL_NUM_PERIPH; gi++) begin : g_pflag
      assign pflag_next[gi] = (wr_pflag ? reg_wdata[gi] : pflag_reg[gi]) ||
                              events.periph[gi];
      chk_periph_bit: assert property (@(posedge clk)
        disable iff (!rst_n) events.periph[gi] |=> pflag_reg[gi])
        else $error("peripheral flag bit not set");
    end
  endgenerate
  assign pen_next = wr_pen ? reg_wdata : pen_reg;

  always_comb begin
    stat_next = wr_stat ? reg_wdata : stat_reg;
    if (state_reg == CIL_SLEEP && wake_src) begin
      stat_next[CIL_BIT_WDX] = 1'b1;
      stat_next[CIL_BIT_SLP] = 1'b0;
    end else if (sleep_op && state_reg == CIL_RUN) begin
      stat_next[CIL_BIT_SLP] = 1'b0;
    end
  end

  assign rdata_next = !reg_rd ? 8'h00 :
                      addr_hit(reg_addr, CIL_ADDR_CTRL) ? ctrl_reg :
                      addr_hit(reg_addr, CIL_ADDR_PFLAG) ? pflag_reg :
                      addr_hit(reg_addr, CIL_ADDR_PEN) ? pen_reg : stat_reg;

  always_comb begin
    state_next = state_reg;
    pend_next = pend_reg;
    lat_next = lat_reg;
    redir_next = 3'h0;
    case (state_reg)
      CIL_RUN: begin
        if (take) begin
          pend_next = 1'b1;
          lat_next = 2'(CIL_LAT_SYNC - 1);
          redir_next[2] = 1'b1;
        end else if (sleep_op) begin
          state_next = CIL_SLEEP;
        end
      end
      CIL_SLEEP: begin
        if (wake_src) begin
          state_next = CIL_WAKE;
        end
      end
      default: begin
        if (instr_cycle) begin
          state_next = CIL_RUN;
        end
      end
    endcase
    if (pend_reg && instr_cycle) begin
      if (lat_reg == 2'h0) begin
        pend_next = 1'b0;
        // push and load vector in the same cycle; only pc saved
        redir_next[1] = 1'b1;
        redir_next[0] = 1'b1;
      end else begin
        lat_next = lat_reg - 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CIL_CTRL_RST;
      pflag_reg <= CIL_PFLAG_RST;
      pen_reg <= CIL_PEN_RST;
      stat_reg <= CIL_STAT_RST;
      rdata_reg <= 8'h00;
      // take the pin level so release brings no false edge
      ext_pin_reg <= ext_pin;
      state_reg <= CIL_RUN;
      lat_reg <= 2'h0;
      pend_reg <= 1'b0;
      redir_reg <= 3'h0;
      irq_reg <= 1'b0;
      asleep_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      pflag_reg <= pflag_next;
      pen_reg <= pen_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      ext_pin_reg <= ext_pin;
      state_reg <= state_next;
      lat_reg <= lat_next;
      pend_reg <= pend_next;
      redir_reg <= redir_next;
      irq_reg <= ctrl_reg[CIL_BIT_GIE] && any_hit;
      asleep_reg <= (state_next == CIL_SLEEP);
    end
  end

  assign reg_rdata = rdata_reg;
  assign redirect.flush = redir_reg[2];
  assign redirect.push = redir_reg[1];
  assign redirect.load_vec = redir_reg[0];
  assign redirect.vector = CIL_VECTOR;
  assign irq_request = irq_reg;
  assign core_asleep = asleep_reg;

  // checker helper: instruction cycles since acceptance
  logic [2:0] ic_seen_reg;
  always_ff @(posedge clk) begin
    if (!rst_n || take) begin
      ic_seen_reg <= 3'h0;
    end else if (pend_reg && instr_cycle && ic_seen_reg != 3'h7) begin
      ic_seen_reg <= ic_seen_reg + 3'h1;
    end
  end

  // checks
  chk_reset_disables: assert property (@(posedge clk)
    !rst_n |=> !ctrl_reg[CIL_BIT_GIE] && !irq_request)
    else $error("interrupts enabled after reset");
  chk_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
    events.timer0_ovf |=> ctrl_reg[CIL_BIT_T0F])
    else $error("timer flag not set by event");
  chk_periph_flag: assert property (@(posedge clk) disable iff (!rst_n)
    events.periph[0] |=> pflag_reg[0])
    else $error("peripheral flag not set");
  chk_gie_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    take && !return_from_service_op |=> !ctrl_reg[CIL_BIT_GIE])
    else $error("global enable not cleared on entry");
  chk_flush_first: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> redirect.flush)
    else $error("no flush on acceptance");
  chk_no_take_off: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[CIL_BIT_GIE] |=> !redirect.flush)
    else $error("vectoring with global enable clear");
  chk_return_sets: assert property (@(posedge clk) disable iff (!rst_n)
    return_from_service_op |=> ctrl_reg[CIL_BIT_GIE])
    else $error("return did not set global enable");
  chk_push_vector: assert property (@(posedge clk) disable iff (!rst_n)
    redirect.load_vec |-> redirect.push && redirect.vector == CIL_VECTOR)
    else $error("vector without push");
  chk_wake_status: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_SLEEP && wake_src && !wr_stat |=>
      stat_reg[CIL_BIT_WDX] && !stat_reg[CIL_BIT_SLP])
    else $error("wake status bits wrong");
  chk_irq_term: assert property (@(posedge clk) disable iff (!rst_n)
    irq_request == $past(ctrl_reg[CIL_BIT_GIE] && any_hit))
    else $error("request term mismatch");

  chk_ext_rise: assert property (@(posedge clk) disable iff (!rst_n)
    ext_edge_select && ext_pin && !ext_pin_reg |=> ctrl_reg[CIL_BIT_EXF])
    else $error("rising edge did not set external flag");
  chk_ext_fall: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_edge_select && !ext_pin && ext_pin_reg |=> ctrl_reg[CIL_BIT_EXF])
    else $error("falling edge did not set external flag");
  chk_pin_change: assert property (@(posedge clk) disable iff (!rst_n)
    events.pin_change |=> ctrl_reg[CIL_BIT_PCF])
    else $error("pin change flag not set");
  chk_gie_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[CIL_BIT_GIE] |=> !irq_request)
    else $error("request with global enable clear");
  chk_group_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[CIL_BIT_PGE] && !core_hit |=> !irq_request)
    else $error("peripheral request with group enable clear");
  chk_sleep_in: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_RUN && sleep_op && !take |=> core_asleep)
    else $error("sleep not entered");
  chk_wake_out: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_SLEEP && wake_src |=> !core_asleep)
    else $error("enabled source did not wake the core");
  chk_wake_flag: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_SLEEP && wake_src && !reg_wr |=>
      (|ctrl_reg[CIL_BIT_T0F:CIL_BIT_PCF]) || (|pflag_reg))
    else $error("wake without any flag set");
  chk_wake_first: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_WAKE |=> !redirect.flush)
    else $error("vectoring before the instruction after sleep");
  chk_latency: assert property (@(posedge clk) disable iff (!rst_n)
    redirect.load_vec |-> ic_seen_reg == 3'(CIL_LAT_SYNC))
    else $error("vector latency wrong");
  chk_flush_once: assert property (@(posedge clk) disable iff (!rst_n)
    redirect.flush |=> !redirect.flush)
    else $error("flush longer than one cycle");
  chk_load_once: assert property (@(posedge clk) disable iff (!rst_n)
    redirect.load_vec |=> !redirect.load_vec)
    else $error("vector load longer than one cycle");
  chk_sleep_stat: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_RUN && sleep_op && !take && !wr_stat |=>
      !stat_reg[CIL_BIT_SLP])
    else $error("sleep entry bit not cleared");
  // read data only after a read
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read strobe");
  chk_pend_block: assert property (@(posedge clk) disable iff (!rst_n)
    pend_reg |=> !redirect.flush)
    else $error("second entry while vectoring");
  cov_take: cover property (@(posedge clk) disable iff (!rst_n)
    take ##[1:40] redirect.load_vec);
  cov_wake: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == CIL_SLEEP ##1 state_reg == CIL_WAKE);
  cov_return: cover property (@(posedge clk) disable iff (!rst_n)
    redirect.load_vec ##[1:100] return_from_service_op);
  cov_ext_edge: cover property (@(posedge clk) disable iff (!rst_n)
    ext_edge ##1 ctrl_reg[CIL_BIT_EXF]);
  cov_periph_take: cover property (@(posedge clk) disable iff (!rst_n)
    periph_hit && take);
endmodule

// [rtl/cil_pkg.sv]
// package: constants and carrier types of the core interrupt logic
package cil_pkg;
  localparam int CIL_NUM_SRC = 11;
  localparam int CIL_NUM_PERIPH = 8;
  localparam logic [1:0] CIL_ADDR_CTRL = 2'h0;
  localparam logic [1:0] CIL_ADDR_PFLAG = 2'h1;
  localparam logic [1:0] CIL_ADDR_PEN = 2'h2;
  localparam logic [1:0] CIL_ADDR_STAT = 2'h3;
  localparam int CIL_BIT_GIE = 7;
  localparam int CIL_BIT_PGE = 6;
  localparam int CIL_BIT_T0E = 5;
  localparam int CIL_BIT_EXE = 4;
  localparam int CIL_BIT_PCE = 3;
  localparam int CIL_BIT_T0F = 2;
  localparam int CIL_BIT_EXF = 1;
  localparam int CIL_BIT_PCF = 0;
  localparam int CIL_BIT_WDX = 4;
  localparam int CIL_BIT_SLP = 3;
  localparam logic [7:0] CIL_CTRL_RST = 8'h00;
  localparam logic [7:0] CIL_PFLAG_RST = 8'h00;
  localparam logic [7:0] CIL_PEN_RST = 8'h00;
  localparam logic [7:0] CIL_STAT_RST = 8'h18;
  localparam logic [12:0] CIL_VECTOR = 13'h0004;
  localparam int CIL_LAT_SYNC = 3;

  typedef enum logic [1:0] {
    CIL_RUN = 2'b00,
    CIL_SLEEP = 2'b01,
    CIL_WAKE = 2'b10
  } cil_state_e;

  typedef struct packed {
    logic timer0_ovf;
    logic ext_pin;
    logic pin_change;
    logic [7:0] periph;
  } cil_events_s;

  typedef struct packed {
    logic flush;
    logic push;
    logic load_vec;
    logic [12:0] vector;
  } cil_redirect_s;
endpackage

// [verif/cil_core_interrupt_test.sv]
// testbench of the core interrupt logic
`timescale 1ns/10ps
module cil_core_interrupt_test
  import cil_pkg::*;
;
  logic clk, rst_n, reg_wr, reg_rd, ext_pin, sel, ic, slp, ret;
  logic irq, asleep;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic [12:0] pc;
  cil_events_s ev, e0;
  cil_redirect_s redirect;
  int fails, tests_run, cyc, k, s;
  cil_core_interrupt i_cil_core_interrupt(.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(ev),
    .ext_pin(ext_pin), .ext_edge_select(sel), .instr_cycle(ic),
    .sleep_op(slp), .return_from_service_op(ret), .redirect(redirect),
    .irq_request(irq), .core_asleep(asleep));
  cil_core_partner i_cil_core_partner(.clk(clk), .rst_n(rst_n),
    .redirect(redirect), .ret_op(ret), .instr_cycle(ic), .pc(pc));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e, string n);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(n, {8'h00, e}, {8'h00, got});
  endtask
  task automatic pulse(cil_events_s e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= '0;
  endtask
  // waits a bounded time for the vector load, then checks the pc
  task automatic wait_vec();
    for (int i = 0; i < 60 && redirect.load_vec !== 1'b1; i++)
      @(posedge clk) #1;
    @(posedge clk) #1;
    chk("pc", {3'h0, CIL_VECTOR}, {3'h0, pc});
  endtask
  task automatic end_of_test();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    ev = '0; e0 = '0; ext_pin = 1; sel = 0; slp = 0; ret = 0;
    void'($urandom(37));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(CIL_ADDR_CTRL, CIL_CTRL_RST, "ctrl");
    rd(CIL_ADDR_PFLAG, CIL_PFLAG_RST, "pflag");
    rd(CIL_ADDR_PEN, CIL_PEN_RST, "pen");
    rd(CIL_ADDR_STAT, CIL_STAT_RST, "stat");
    $display("test reset done");
    e0.timer0_ovf = 1'b1;
    pulse(e0);
    rd(CIL_ADDR_CTRL, 8'h04, "ctrl flag");
    chk("irq off", 16'h0, {15'h0, irq});
    wr(CIL_ADDR_CTRL, 8'hA4);
    wait_vec();
    rd(CIL_ADDR_CTRL, 8'h24, "ctrl taken");
    chk("irq in service", 16'h0, {15'h0, irq});
    wr(CIL_ADDR_CTRL, 8'h20);
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    rd(CIL_ADDR_CTRL, 8'hA0, "ctrl return");
    chk("irq cleared", 16'h0, {15'h0, irq});
    wr(CIL_ADDR_CTRL, 8'h00);
    $display("test timer0 done");
    k = $urandom % 8;
    e0 = '0;
    e0.periph = 8'h01 << k;
    wr(CIL_ADDR_PEN, e0.periph);
    pulse(e0);
    rd(CIL_ADDR_PFLAG, e0.periph, "pflag");
    wr(CIL_ADDR_CTRL, 8'h80);
    repeat (2) @(posedge clk) #1;
    chk("irq no group", 16'h0, {15'h0, irq});
    wr(CIL_ADDR_CTRL, 8'hC0);
    @(posedge clk) #1 chk("irq group", 16'h1, {15'h0, irq});
    wait_vec();
    wr(CIL_ADDR_PFLAG, 8'h00);
    wr(CIL_ADDR_CTRL, 8'h00);
    $display("test periph done");
    for (s = 0; s < 2; s++) begin
      @(posedge clk) sel <= s[0];
      ext_pin <= !s[0];
      repeat (2) @(posedge clk);
      wr(CIL_ADDR_CTRL, 8'h00);
      ext_pin <= s[0];
      rd(CIL_ADDR_CTRL, 8'h02, "ext edge");
    end
    wr(CIL_ADDR_CTRL, 8'h90);
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    @(posedge clk) #1 chk("asleep", 16'h1, {15'h0, asleep});
    @(posedge clk) ext_pin <= 1'b0;
    @(posedge clk) ext_pin <= 1'b1;
    wait_vec();
    rd(CIL_ADDR_STAT, 8'h10, "stat wake");
    rd(CIL_ADDR_CTRL, 8'h12, "ctrl wake");
    chk("awake", 16'h0, {15'h0, asleep});
    $display("test sleep done");
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(CIL_ADDR_CTRL, CIL_CTRL_RST, "ctrl reset");
    chk("irq reset", 16'h0, {15'h0, irq});
    $display("test second reset done");
    end_of_test();
  end
endmodule

// [verif/cil_core_partner.sv]
// partner model: core program counter and hardware stack
`timescale 1ns/10ps
module cil_core_partner
  import cil_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire cil_redirect_s redirect,
  input wire logic ret_op,
  output logic instr_cycle,
  output logic [12:0] pc
);
  logic [1:0] phase;
  logic [12:0] stack[$];
  // four clocks make one instruction cycle
  assign instr_cycle = rst_n && phase == 2'h3;
  always @(posedge clk) begin
    if (!rst_n) begin
      phase <= 2'h0;
      pc <= 13'h0000;
      stack.delete();
    end else begin
      phase <= phase + 2'h1;
      if (instr_cycle) pc <= pc + 13'h0001;
      // only the return pc is saved
      if (redirect.push) stack.push_back(pc);
      if (redirect.load_vec) pc <= redirect.vector;
      if (ret_op && stack.size() > 0) pc <= stack.pop_back();
    end
  end
endmodule
